// File: verilog/step_decoder_cfg.svh
// Purpose: constants of the step pulse command decoder
// Assumes: 10 MHz mclk
// Notes: definitions only
`ifndef STEP_DECODER_CFG_SVH
`define STEP_DECODER_CFG_SVH
`define POS_W 16
`define OFS_W 8
`define SYNC_W 23
`define MODE_SWITCH 3'h0
`define MODE_TWO_LOW 3'h1
`define MODE_TWO_HIGH 3'h2
`define MODE_ONE_LOW 3'h3
`define MODE_ONE_HIGH 3'h4
`define MODE_QUAD_X1 3'h5
`define MODE_QUAD_X2 3'h6
`define MODE_QUAD_X4 3'h7
`define CFG_LOAD_AT 2'h3
`define END_WINDOW 16'h0003
`define END_OFS_MAX 8'sh12
`define ELEC_MASK 16'h0003
`define CLK_PERIOD_NS 100
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES 4'((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/step_decoder_pkg.sv
// Purpose: types of the step pulse command decoder
// Assumes: constants from the cfg header
// Notes: none
`include "step_decoder_cfg.svh"
package step_decoder_pkg;
  typedef logic signed [`POS_W-1:0] pos_t;
  typedef logic signed [`OFS_W-1:0] ofs_t;
  typedef enum logic [2:0] {ST_OFF = 3'h1, ST_RUN = 3'h2, ST_RETURN = 3'h4} drive_state_t;
endpackage

// File: verilog/step_pulse_command_decoder.sv
// Purpose: pulse train to command position, excitation and auto return
// Assumes: detectedPos comes from logic on mclk; all other inputs are pins
// Notes: positions in counts; offset clamped to +-18 counts
`timescale 1ns/10ps
`default_nettype none
`include "step_decoder_cfg.svh"
module step_pulse_command_decoder (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic step_pulse_in,
  input wire logic directionIn,
  input wire logic forward_pulse_in,
  input wire logic reverse_pulse_in,
  input wire logic currentEnableIn,
  input wire logic freeShaftIn,
  input wire logic modeSelectSwitch,
  input wire logic [2:0] pulseModeCfg,
  input wire logic excitePosCfg,
  input wire logic enablePolarityCfg,
  input wire logic autoReturnCfg,
  input wire logic dirPolarityCfg,
  input wire logic acPowerStrap,
  input wire step_decoder_pkg::ofs_t endOffsetCfg,
  input wire step_decoder_pkg::pos_t detectedPos,
  output step_decoder_pkg::pos_t commandPos,
  output logic stepStrobe,
  output logic stepForward,
  output logic clockwiseRotation,
  output logic motorExcited,
  output logic exciteAtZero,
  output logic returnActive,
  output logic returnForward,
  output logic positioningComplete,
  output logic electrical_zero_out,
  output logic configLoaded
);
  import step_decoder_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [`SYNC_W-1:0] rawIn;
  logic [`SYNC_W-1:0] syncA;
  logic [`SYNC_W-1:0] syncB;
  logic [`SYNC_W-1:0] prevB;
  assign rawIn = {endOffsetCfg, acPowerStrap, dirPolarityCfg, autoReturnCfg, enablePolarityCfg, excitePosCfg,
                  pulseModeCfg, modeSelectSwitch, freeShaftIn, currentEnableIn, reverse_pulse_in,
                  forward_pulse_in, directionIn, step_pulse_in};
  // two stages per pin, then an edge history stage
  for (genvar i = 0; i < `SYNC_W; i++) begin : g_sync
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        syncA[i] <= 1'b0;
        syncB[i] <= 1'b0;
        prevB[i] <= 1'b0;
      end else begin
        syncA[i] <= rawIn[i];
        syncB[i] <= syncA[i];
        prevB[i] <= syncB[i];
      end
    end
  end
  logic sStep, sDir, sFwd, sRev, sCen, sFree, sSw, pStep, pFwd, pRev, pCen, pFree;
  logic sAc, sDirPol, sAuto, sCenPol, sExc;
  logic [2:0] sMode;
  ofs_t sOfs;
  assign {sOfs, sAc, sDirPol, sAuto, sCenPol, sExc, sMode, sSw, sFree, sCen, sRev, sFwd, sDir, sStep} = syncB;
  assign {pFree, pCen, pRev, pFwd} = prevB[5:2];
  assign pStep = prevB[0];

  // ----------------------------------------
  // power-up configuration latch
  // ----------------------------------------
  logic [1:0] loadCnt, next_loadCnt;
  logic [2:0] modeCfg, next_modeCfg;
  logic exciteZeroCfg, cenPol, autoRet, dirPol, acVariant;
  logic next_exciteZeroCfg, next_cenPol, next_autoRet, next_dirPol, next_acVariant;
  ofs_t endOfs, next_endOfs;
  // capture once, a fixed count after reset release
  always_comb begin
    next_loadCnt = loadCnt;
    {next_modeCfg, next_exciteZeroCfg, next_cenPol, next_autoRet, next_dirPol, next_acVariant} =
      {modeCfg, exciteZeroCfg, cenPol, autoRet, dirPol, acVariant};
    next_endOfs = endOfs;
    if (loadCnt != `CFG_LOAD_AT) begin
      next_loadCnt = loadCnt + 2'h1;
    end
    if (loadCnt == `CFG_LOAD_AT - 2'h1) begin
      {next_modeCfg, next_exciteZeroCfg, next_cenPol, next_autoRet, next_dirPol, next_acVariant} =
        {sMode, sExc, sCenPol, sAuto, sDirPol, sAc};
      next_endOfs = (sOfs > `END_OFS_MAX) ? `END_OFS_MAX : (sOfs < -`END_OFS_MAX) ? -`END_OFS_MAX : sOfs;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      loadCnt <= 2'h0;
      modeCfg <= `MODE_SWITCH;
      exciteZeroCfg <= 1'b0;
      cenPol <= 1'b0;
      autoRet <= 1'b0;
      dirPol <= 1'b1;
      acVariant <= 1'b0;
      endOfs <= 8'sh00;
    end else begin
      loadCnt <= next_loadCnt;
      {modeCfg, exciteZeroCfg, cenPol, autoRet, dirPol, acVariant} <=
        {next_modeCfg, next_exciteZeroCfg, next_cenPol, next_autoRet, next_dirPol, next_acVariant};
      endOfs <= next_endOfs;
    end
  end
  assign configLoaded = (loadCnt == `CFG_LOAD_AT);

  // ----------------------------------------
  // pulse decoding and command position
  // ----------------------------------------
  logic [2:0] effMode;
  logic lowAct, stepRise, fwdRise, revRise, aEdge, bEdge, doStep, fwdStep;
  logic [3:0] settleCnt, next_settleCnt;
  pos_t next_commandPos;
  logic next_stepStrobe, next_stepForward, next_cw;
  // mode 0 defers to the switch: 0 two-pulse, 1 single-pulse
  assign effMode = (modeCfg == `MODE_SWITCH) ? (sSw ? `MODE_ONE_HIGH : `MODE_TWO_HIGH) : modeCfg;
  assign lowAct = (effMode == `MODE_TWO_LOW) || (effMode == `MODE_ONE_LOW);
  assign stepRise = (sStep ^ lowAct) & ~(pStep ^ lowAct);
  assign fwdRise = (sFwd ^ lowAct) & ~(pFwd ^ lowAct);
  assign revRise = (sRev ^ lowAct) & ~(pRev ^ lowAct);
  assign aEdge = sFwd ^ pFwd;
  assign bEdge = sRev ^ pRev;
  always_comb begin
    doStep = 1'b0;
    fwdStep = 1'b0;
    unique case (effMode)
      `MODE_ONE_LOW, `MODE_ONE_HIGH: begin
        doStep = stepRise;
        fwdStep = sDir;
      end
      `MODE_QUAD_X1: begin
        doStep = aEdge & ~bEdge & sFwd;
        fwdStep = ~sRev;
      end
      `MODE_QUAD_X2: begin
        doStep = aEdge & ~bEdge;
        fwdStep = sFwd != sRev;
      end
      `MODE_QUAD_X4: begin
        doStep = aEdge ^ bEdge; // both lines moving at once is ignored
        fwdStep = aEdge ? (sFwd != sRev) : (sRev == sFwd);
      end
      default: begin
        doStep = fwdRise ^ revRise;
        fwdStep = fwdRise;
      end
    endcase
    doStep = doStep & configLoaded;
    next_commandPos = commandPos;
    if (doStep) begin
      next_commandPos = fwdStep ? commandPos + pos_t'(1) : commandPos - pos_t'(1);
    end
    next_stepStrobe = doStep;
    next_stepForward = doStep ? fwdStep : stepForward;
    next_cw = doStep ? (fwdStep == dirPol) : clockwiseRotation;
    next_settleCnt = doStep ? 4'h0 : (settleCnt == `SETTLE_CYCLES) ? settleCnt : settleCnt + 4'h1;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      commandPos <= '0;
      stepStrobe <= 1'b0;
      stepForward <= 1'b0;
      clockwiseRotation <= 1'b0;
      settleCnt <= 4'h0;
    end else begin
      commandPos <= next_commandPos;
      stepStrobe <= next_stepStrobe;
      stepForward <= next_stepForward;
      clockwiseRotation <= next_cw;
      settleCnt <= next_settleCnt;
    end
  end

  // ----------------------------------------
  // excitation and auto return
  // ----------------------------------------
  drive_state_t state, next_state;
  logic cenOn, cenRise, freeFall, wake, pwrPending, next_pwrPending, firstDone, next_firstDone;
  logic next_exciteAtZero, next_returnForward, next_posComplete, next_elecZero;
  pos_t deviation, shiftedErr, absErr;
  assign cenOn = sCen ^ cenPol;
  assign cenRise = cenOn & ~(pCen ^ cenPol);
  assign freeFall = ~sFree & pFree;
  assign wake = configLoaded & cenOn & ~sFree;
  assign deviation = commandPos - detectedPos;
  assign shiftedErr = deviation - pos_t'(endOfs);
  assign absErr = shiftedErr[`POS_W-1] ? -shiftedErr : shiftedErr;
  always_comb begin
    next_state = state;
    next_firstDone = firstDone;
    next_exciteAtZero = exciteAtZero;
    next_pwrPending = pwrPending | ((loadCnt == `CFG_LOAD_AT - 2'h1) & sAuto & sAc);
    unique case (state)
      ST_OFF: begin
        if (wake) begin
          next_state = (autoRet & (cenRise | freeFall | pwrPending)) ? ST_RETURN : ST_RUN;
          next_pwrPending = 1'b0;
          next_firstDone = 1'b1;
          if (!firstDone) begin
            next_exciteAtZero = exciteZeroCfg | cenPol;
          end
        end
      end
      ST_RUN: begin
        if (!cenOn || sFree) begin
          next_state = ST_OFF;
        end
      end
      ST_RETURN: begin
        if (!cenOn || sFree) begin
          next_state = ST_OFF;
        end else if (deviation == '0) begin
          next_state = ST_RUN;
        end
      end
      default: next_state = ST_OFF;
    endcase
    next_returnForward = ~deviation[`POS_W-1];
    next_posComplete = (state == ST_RUN) && (settleCnt == `SETTLE_CYCLES) && (absErr <= `END_WINDOW);
    next_elecZero = (detectedPos & `ELEC_MASK) == '0;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
      firstDone <= 1'b0;
      exciteAtZero <= 1'b0;
      pwrPending <= 1'b0;
      returnForward <= 1'b0;
      positioningComplete <= 1'b0;
      electrical_zero_out <= 1'b0;
    end else begin
      state <= next_state;
      firstDone <= next_firstDone;
      exciteAtZero <= next_exciteAtZero;
      pwrPending <= next_pwrPending;
      returnForward <= next_returnForward;
      positioningComplete <= next_posComplete;
      electrical_zero_out <= next_elecZero;
    end
  end
  assign motorExcited = (state != ST_OFF);
  assign returnActive = (state == ST_RETURN);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_wakeCen;
    state == ST_OFF && wake && autoRet && cenRise;
  endsequence
  sequence s_wakeFree;
    state == ST_OFF && wake && autoRet && freeFall;
  endsequence
  sequence s_returning;
    returnActive && motorExcited;
  endsequence
  property p_single;
    configLoaded && effMode == `MODE_ONE_HIGH && stepRise && sDir |=> stepStrobe && stepForward;
  endproperty
  a_single: assert property (p_single) else $error("single-pulse step lost");
  property p_two;
    configLoaded && effMode == `MODE_TWO_HIGH && revRise && !fwdRise |=> stepStrobe && !stepForward;
  endproperty
  a_two: assert property (p_two) else $error("reverse line did not step back");
  property p_lag;
    configLoaded && effMode == `MODE_QUAD_X4 && aEdge && !bEdge && sFwd != sRev |=> stepStrobe && stepForward;
  endproperty
  a_lag: assert property (p_lag) else $error("lagging line not forward");
  property p_lead;
    configLoaded && effMode == `MODE_QUAD_X4 && bEdge && !aEdge && sFwd != sRev |=> stepStrobe && !stepForward;
  endproperty
  a_lead: assert property (p_lead) else $error("leading line not reverse");
  property p_inc;
    stepStrobe && stepForward |-> commandPos - $past(commandPos) == pos_t'(1);
  endproperty
  a_inc: assert property (p_inc) else $error("forward step did not increment");
  property p_dec;
    stepStrobe && !stepForward |-> $past(commandPos) - commandPos == pos_t'(1);
  endproperty
  a_dec: assert property (p_dec) else $error("reverse step did not decrement");
  property p_sense;
    stepStrobe |-> clockwiseRotation == (stepForward == dirPol);
  endproperty
  a_sense: assert property (p_sense) else $error("rotation sense wrong");
  property p_hold;
    configLoaded |=> $stable(modeCfg) && $stable(dirPol) && $stable(autoRet) && $stable(endOfs);
  endproperty
  a_hold: assert property (p_hold) else $error("setting changed after power-up");
  property p_retCen;
    s_wakeCen |=> s_returning;
  endproperty
  a_retCen: assert property (p_retCen) else $error("no return on enable");
  property p_retFree;
    s_wakeFree |=> s_returning;
  endproperty
  a_retFree: assert property (p_retFree) else $error("no return on free release");
  property p_nc;
    state == ST_OFF && configLoaded && cenPol && !sCen && !sFree |=> motorExcited ##0 exciteAtZero;
  endproperty
  a_nc: assert property (p_nc) else $error("normally closed did not excite");
  property p_window;
    positioningComplete |-> $past(absErr) <= `END_WINDOW && $past(state) == ST_RUN;
  endproperty
  a_window: assert property (p_window) else $error("complete outside window");
endmodule
`default_nettype wire

// File: testbench/step_pulse_source.sv
// Purpose: pulse generator in the place of the motion controller
// Assumes: lines change only at falling edges of mclk
// Notes: every level is held 3 cycles, above the 2-cycle minimum
`timescale 1ns/10ps
`default_nettype none
module step_pulse_source (
  input wire logic mclk,
  output var logic stepLine,
  output var logic dirLine,
  output var logic fwdLine,
  output var logic revLine
);
  // ----------------------------------------
  // line drivers
  // ----------------------------------------
  initial begin
    stepLine = 1'h0;
    dirLine = 1'h1;
    fwdLine = 1'h0;
    revLine = 1'h0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // one pulse line: 0 step, 1 forward, 2 reverse
  task automatic setLine(input int line, input logic lvl);
    case (line)
      0: stepLine = lvl;
      1: fwdLine = lvl;
      default: revLine = lvl;
    endcase
  endtask
  // idle level of all pulse lines, high for active-low inputs
  task automatic setIdle(input logic lvl);
    stepLine = lvl;
    fwdLine = lvl;
    revLine = lvl;
  endtask
  // sense first, then one pulse away from idle and back
  task automatic pulse(input int line, input logic idle, input logic dirLevel);
    dirLine = dirLevel;
    hold(3);
    setLine(line, ~idle);
    hold(3);
    setLine(line, idle);
    hold(3);
  endtask
  // one full quadrature cycle; forward has the reverse line lagging
  task automatic quad(input logic fwd);
    logic [1:0] s;
    for (int k = 0; k < 4; k++) begin
      s = 2'(8'hB4 >> (6 - 2 * k));
      fwdLine = fwd ? s[1] : s[0];
      revLine = fwd ? s[0] : s[1];
      hold(3);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the step pulse command decoder
// Assumes: settings reload at every reset release
// Notes: each row restarts the design with its own settings
`timescale 1ns/10ps
`default_nettype none
`include "step_decoder_cfg.svh"
module tb_top;
  import step_decoder_pkg::*;
  typedef struct packed {logic [2:0] mode; logic sw; logic dirPol; logic [2:0] act; logic signed [7:0] delta;} row_t;
  logic mclk, reset_n, currentEnableIn, freeShaftIn, modeSelectSwitch, excitePosCfg, enablePolarityCfg;
  logic autoReturnCfg, dirPolarityCfg, acPowerStrap, stepStrobe, stepForward, clockwiseRotation;
  logic motorExcited, exciteAtZero, returnActive, returnForward, positioningComplete, elecZero, configLoaded;
  logic stepLine, dirLine, fwdLine, revLine, lowAct;
  logic [2:0] pulseModeCfg;
  ofs_t endOffsetCfg;
  pos_t detectedPos, commandPos;
  int fails = 0, checksDone = 0, cycles = 0, n;
  row_t r;
  row_t rows [16] = '{'{3'h2, 1'h0, 1'h1, 3'h0, 8'h01}, '{3'h2, 1'h0, 1'h0, 3'h1, 8'hFF},
    '{3'h1, 1'h0, 1'h1, 3'h0, 8'h01}, '{3'h1, 1'h0, 1'h0, 3'h1, 8'hFF}, '{3'h4, 1'h0, 1'h1, 3'h2, 8'h01},
    '{3'h4, 1'h0, 1'h0, 3'h3, 8'hFF}, '{3'h3, 1'h0, 1'h1, 3'h2, 8'h01}, '{3'h3, 1'h0, 1'h1, 3'h3, 8'hFF},
    '{3'h0, 1'h0, 1'h1, 3'h1, 8'hFF}, '{3'h0, 1'h1, 1'h0, 3'h2, 8'h01}, '{3'h7, 1'h0, 1'h1, 3'h4, 8'h04},
    '{3'h7, 1'h0, 1'h0, 3'h5, 8'hFC}, '{3'h6, 1'h0, 1'h1, 3'h4, 8'h02}, '{3'h6, 1'h0, 1'h1, 3'h5, 8'hFE},
    '{3'h5, 1'h0, 1'h1, 3'h4, 8'h01}, '{3'h5, 1'h0, 1'h0, 3'h5, 8'hFF}};
  // ----------------------------------------
  // design and controller model
  // ----------------------------------------
  step_pulse_source i_src (.mclk(mclk), .stepLine(stepLine), .dirLine(dirLine), .fwdLine(fwdLine),
    .revLine(revLine));
  step_pulse_command_decoder i_dut (.mclk(mclk), .reset_n(reset_n), .step_pulse_in(stepLine),
    .directionIn(dirLine), .forward_pulse_in(fwdLine), .reverse_pulse_in(revLine),
    .currentEnableIn(currentEnableIn), .freeShaftIn(freeShaftIn), .modeSelectSwitch(modeSelectSwitch),
    .pulseModeCfg(pulseModeCfg), .excitePosCfg(excitePosCfg), .enablePolarityCfg(enablePolarityCfg),
    .autoReturnCfg(autoReturnCfg), .dirPolarityCfg(dirPolarityCfg), .acPowerStrap(acPowerStrap),
    .endOffsetCfg(endOffsetCfg), .detectedPos(detectedPos), .commandPos(commandPos), .stepStrobe(stepStrobe),
    .stepForward(stepForward), .clockwiseRotation(clockwiseRotation), .motorExcited(motorExcited),
    .exciteAtZero(exciteAtZero), .returnActive(returnActive), .returnForward(returnForward),
    .positioningComplete(positioningComplete), .electrical_zero_out(elecZero), .configLoaded(configLoaded));
  // ----------------------------------------
  // clock, timeout and checking tasks
  // ----------------------------------------
  initial begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end
  // cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run;
    if (fails == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmpPos(input pos_t got, input pos_t exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    checksDone++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // reset for 3 cycles, wait for the load, then disturb the mode pins
  task automatic restart(input logic [2:0] mode, input logic sw, input logic dp);
    reset_n = 1'h0;
    pulseModeCfg = mode;
    modeSelectSwitch = sw;
    dirPolarityCfg = dp;
    i_src.hold(3);
    reset_n = 1'h1;
    n = 0;
    while (configLoaded !== 1'h1 && n < 20) begin
      i_src.hold(1);
      n++;
    end
    cmpBit(n == 3, 1'h1);
    pulseModeCfg = mode ^ 3'h4;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'h0;
    {currentEnableIn, freeShaftIn, modeSelectSwitch, excitePosCfg, enablePolarityCfg} = 5'h00;
    {autoReturnCfg, dirPolarityCfg, acPowerStrap} = 3'h2;
    pulseModeCfg = 3'h0;
    endOffsetCfg = 8'h00;
    detectedPos = 16'h0000;
    i_src.hold(1);
    // table of modes and pulse kinds
    for (int i = 0; i < 16; i++) begin
      r = rows[i];
      lowAct = (r.mode == `MODE_TWO_LOW) || (r.mode == `MODE_ONE_LOW);
      i_src.setIdle(lowAct);
      restart(r.mode, r.sw, r.dirPol);
      case (r.act)
        3'h0: i_src.pulse(1, lowAct, 1'h1);
        3'h1: i_src.pulse(2, lowAct, 1'h1);
        3'h2: i_src.pulse(0, lowAct, 1'h1);
        3'h3: i_src.pulse(0, lowAct, 1'h0);
        default: i_src.quad(r.act == 3'h4);
      endcase
      i_src.hold(4);
      cmpPos(commandPos, pos_t'(r.delta));
      cmpBit(stepForward, ~r.delta[7]);
      cmpBit(clockwiseRotation, r.delta[7] ^ r.dirPol);
    end
    // strobe latency, then both lines at once cancel
    i_src.setIdle(1'h0);
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    i_src.setLine(1, 1'h1);
    n = 0;
    while (stepStrobe !== 1'h1 && n < 8) begin
      i_src.hold(1);
      n++;
    end
    cmpBit(n == 3, 1'h1);
    i_src.hold(1);
    cmpBit(stepStrobe, 1'h0);
    i_src.setLine(1, 1'h0);
    i_src.hold(3);
    i_src.setIdle(1'h1);
    i_src.hold(3);
    i_src.setIdle(1'h0);
    i_src.hold(6);
    cmpPos(commandPos, 16'h0001);
    // excitation, auto return and completion window
    autoReturnCfg = 1'h1;
    detectedPos = 16'hFFFB;
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    currentEnableIn = 1'h1;
    i_src.hold(8);
    cmpBit(motorExcited, 1'h1);
    cmpBit(exciteAtZero, 1'h0);
    cmpBit(returnActive, 1'h1);
    cmpBit(returnForward, 1'h1);
    cmpBit(elecZero, 1'h0);
    detectedPos = 16'h0000;
    i_src.hold(4);
    cmpBit(returnActive, 1'h0);
    cmpBit(elecZero, 1'h1);
    i_src.hold(14);
    cmpBit(positioningComplete, 1'h1);
    detectedPos = 16'h0004;
    i_src.hold(3);
    cmpBit(positioningComplete, 1'h0);
    endOffsetCfg = 8'hFC;
    i_src.hold(14);
    cmpBit(positioningComplete, 1'h0);
    // the new offset only counts after a fresh power-up
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    i_src.hold(14);
    cmpBit(positioningComplete, 1'h1);
    freeShaftIn = 1'h1;
    i_src.hold(5);
    cmpBit(motorExcited, 1'h0);
    freeShaftIn = 1'h0;
    i_src.hold(5);
    cmpBit(returnActive, 1'h1);
    // electrical-zero choice on a normally open enable
    {autoReturnCfg, excitePosCfg, currentEnableIn} = 3'h2;
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    currentEnableIn = 1'h1;
    i_src.hold(6);
    cmpBit(exciteAtZero, 1'h1);
    // normally closed enable excites with the pin low
    {excitePosCfg, enablePolarityCfg, currentEnableIn} = 3'h2;
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    i_src.hold(6);
    cmpBit(motorExcited, 1'h1);
    cmpBit(exciteAtZero, 1'h1);
    currentEnableIn = 1'h1;
    i_src.hold(6);
    cmpBit(motorExcited, 1'h0);
    // mains variant returns at power-up with the enable already on
    {autoReturnCfg, enablePolarityCfg, acPowerStrap} = 3'h5;
    detectedPos = 16'h0005;
    restart(`MODE_TWO_HIGH, 1'h0, 1'h1);
    i_src.hold(4);
    cmpBit(returnActive, 1'h1);
    cmpBit(returnForward, 1'h0);
    complete_run();
  end
endmodule
`default_nettype wire
